// *** rtl/scc_consts.vh ***
/*
  Constants for the sensorless commutation control block: register
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// Register word offsets on the Avalon-MM slave
`define SCC_OFS_MIN_VEL 4'h0
`define SCC_OFS_CTRL 4'h1
`define SCC_OFS_MODE 4'h2
`define SCC_OFS_PWM_SCALE 4'h3
`define SCC_OFS_STATUS 4'h4
`define SCC_OFS_MASK 4'h5
`define SCC_OFS_HIGH_VEL 4'h6
`define SCC_OFS_STATE 4'h7

// Minimum commutation velocity field
`define SCC_MINV_HI 22
`define SCC_MINV_LO 8
`define SCC_MINV_RESET 15'h0000
`define SCC_MINV_FLOOR 15'h0001

// Commutation control fields
`define SCC_ONT_HI 9
`define SCC_ONT_LO 0
`define SCC_SLT_HI 23
`define SCC_SLT_LO 16
`define SCC_CTRL_RESET 24'h000000
`define SCC_SLT_UNIT_LOG2 4

// Mode register bits
`define SCC_MODE_STEPDIR 0
`define SCC_MODE_HS_FULLSTEP 1
`define SCC_MODE_HS_CHOPPER 2
`define SCC_MODE_RESET 3'h0

// Status and mask bits
`define SCC_ST_CMT_ON 0
`define SCC_ST_CMT_OFF 1
`define SCC_ST_STEP_LOSS 2
`define SCC_ST_HIGH_CROSS 3
`define SCC_ST_W 4

// Stall suppression after a high threshold crossing, in electrical periods
`define SCC_SUPP_PERIODS 2'h3

`endif

// *** rtl/scc_ontime.v ***
/*
  PWM on-time limiter: counts the on phase of the chopper and flags
  when the commutation limit or the step-loss limit is reached.
  Assumes pwm_on is a same-clock level from the chopper.
*/
`timescale 1ns/100ps
`include "scc_consts.vh"
module scc_ontime #(
  parameter ONT_W = 10,
  parameter SLT_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Control
  input wire enable,
  input wire pwm_on,
  input wire [ONT_W-1:0] ont_limit,
  input wire [SLT_W-1:0] slt_limit,
  // Results
  output reg cmt_limit_hit_r,
  output reg step_loss_r
);
  localparam CNT_W = SLT_W + `SCC_SLT_UNIT_LOG2 + 1;
  reg [CNT_W-1:0] on_cnt_r;
  wire [CNT_W-1:0] slt_cycles;
  wire [CNT_W-1:0] ont_cycles;

  assign slt_cycles = {1'b0, slt_limit, {`SCC_SLT_UNIT_LOG2{1'b0}}};
  assign ont_cycles = {{(CNT_W-ONT_W){1'b0}}, ont_limit};

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_cnt_r <= {CNT_W{1'b0}};
      cmt_limit_hit_r <= 1'b0;
      step_loss_r <= 1'b0;
    end
    else
    begin
      if (enable && pwm_on)
      begin
        if (on_cnt_r != {CNT_W{1'b1}})
          on_cnt_r <= on_cnt_r + 1'b1;
      end
      else
        on_cnt_r <= {CNT_W{1'b0}};
      // Limit counted in single clock cycles
      cmt_limit_hit_r <= enable && pwm_on && (on_cnt_r >= ont_cycles);
      // Units of sixteen cycles, zero switches detection off
      step_loss_r <= enable && pwm_on && (slt_limit != {SLT_W{1'b0}})
        && (on_cnt_r >= slt_cycles);
    end
  end
endmodule // scc_ontime

// *** rtl/scc_suppress.v ***
/*
  Stall suppression timer: after a high threshold crossing, holds
  stall detection off for a number of electrical periods.
  Assumes elec_period is a one-cycle pulse per electrical period.
*/
`timescale 1ns/100ps
`include "scc_consts.vh"
module scc_suppress (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Events
  input wire crossing,
  input wire elec_period,
  // Result
  output reg suppress_r
);
  reg [1:0] left_r;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_r <= 2'h0;
      suppress_r <= 1'b0;
    end
    else
    begin
      // Counts three period marks so the span is two to three periods
      if (crossing)
      begin
        left_r <= `SCC_SUPP_PERIODS;
        suppress_r <= 1'b1;
      end
      else if (elec_period && left_r != 2'h0)
      begin
        left_r <= left_r - 2'h1;
        suppress_r <= (left_r != 2'h1);
      end
    end
  end
endmodule // scc_suppress

// *** rtl/scc_top.v ***
/*
  Sensorless commutation control: velocity-gated enabling of automatic
  commutation, on-time limits, step-loss detection, high velocity
  actions and PWM amplitude readback, behind an Avalon-MM slave.
  Assumes the ramp generator, chopper and bridge logic on the same clock;
  the external commutation enable is an asynchronous pin.
*/
// Chosen here: register access over Avalon-MM and the placing of the registers.
// Contract
// - With ramp generator, enable commutation only while velocity exceeds minimum; the code also enables at a magnitude equal to the minimum.
// - Step/direction mode ignores minimum velocity; external enable pin decides.
// - Minimum velocity of zero disables automatic commutation, except in step/direction mode.
// - Magnitude at least minimum, minimum at least 256: commutate and do high actions.
// - Only bits 22..8 of minimum velocity are stored and compared.
// - While commutating, position comes from commutation and is written back.
// - Under heavy load, step velocity never drops below minimum velocity.
// - Commutation on-time limit, bits 9..0, counted in single clock cycles.
// - Step-loss limit, bits 23..16, units of sixteen cycles, zero disables.
// - Step-loss detection also works above high setting with fullstep enabled.
// - PWM amplitude scaler readable as eight bits, 255 is maximum.
// - Above high threshold: no adaptive scaling or voltage PWM; chopper, fullstep switch.
// - Stall detection suppressed two to three periods after each high crossing.
`timescale 1ns/100ps
`include "scc_consts.vh"
module scc_top #(
  parameter VEL_W = 32,
  parameter POS_W = 32
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Interrupt
  output reg irq,
  // Motion inputs
  input wire [VEL_W-1:0] actual_velocity,
  input wire [POS_W-1:0] sensorless_position,
  input wire commutation_step,
  input wire commutation_enable_input,
  input wire pwm_on,
  input wire elec_period,
  input wire [7:0] pwm_amplitude,
  // Drive outputs
  output reg commutation_active,
  output reg [POS_W-1:0] actual_position,
  output reg position_load,
  output reg [22:0] min_step_velocity,
  output reg cmt_on_time_limit,
  output reg step_loss,
  output reg stall_suppress,
  output reg adaptive_scaling_off,
  output reg voltage_pwm_off,
  output reg chopper_switch,
  output reg fullstep_mode
);
  reg [14:0] min_vel_r;
  reg [23:0] ctrl_r;
  reg [2:0] mode_r;
  reg [22:0] high_vel_r;
  reg [`SCC_ST_W-1:0] status_r;
  reg [`SCC_ST_W-1:0] mask_r;
  reg [`SCC_ST_W-1:0] status_nxt;
  reg [2:0] pin_sync_r;
  reg pin_level_r;
  reg above_high_r;
  reg cmt_prev_r;
  reg [31:0] rdata_nxt;
  reg [VEL_W-1:0] vel_mag;
  reg cmt_nxt;
  reg above_high_nxt;
  reg in_fullstep;
  reg ack_r;
  wire wr_en;
  wire rd_en;
  wire crossing;
  wire cmt_hit;
  wire loss_hit;
  wire supp;
  wire stall_mask;

  function [VEL_W-1:0] mag;
    input [VEL_W-1:0] v;
    begin
      mag = v[VEL_W-1] ? (~v + 1'b1) : v;
    end
  endfunction

  function above;
    input [VEL_W-1:0] m;
    input [22:0] thr;
    begin
      above = (m >= {{(VEL_W-23){1'b0}}, thr});
    end
  endfunction

  function [22:0] min_vel_scaled;
    input [14:0] m;
    begin
      min_vel_scaled = {m, 8'h00};
    end
  endfunction

  // One wait state per access keeps read data straight from a flop
  assign rd_en = avs_read && !ack_r;
  // Writes land on the edge where the master sees waitrequest low
  assign wr_en = avs_write && ack_r;

  // Bus handshake
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      if (rd_en)
        avs_readdata <= rdata_nxt;
    end
  end

  // Configuration registers
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      min_vel_r <= `SCC_MINV_RESET;
      ctrl_r <= `SCC_CTRL_RESET;
      mode_r <= `SCC_MODE_RESET;
      high_vel_r <= 23'h0;
      mask_r <= {`SCC_ST_W{1'b0}};
    end
    else
    begin
      if (wr_en)
      begin
        case (avs_address)
          `SCC_OFS_MIN_VEL: min_vel_r <= avs_writedata[`SCC_MINV_HI:`SCC_MINV_LO];
          `SCC_OFS_CTRL: ctrl_r <= avs_writedata[23:0];
          `SCC_OFS_MODE: mode_r <= avs_writedata[2:0];
          `SCC_OFS_MASK: mask_r <= avs_writedata[`SCC_ST_W-1:0];
          `SCC_OFS_HIGH_VEL: high_vel_r <= avs_writedata[22:0];
          default: ;
        endcase
      end
    end
  end

  // Write-only registers read as zero; unmapped addresses read zero
  always @*
  begin
    rdata_nxt = 32'h0;
    case (avs_address)
      `SCC_OFS_MODE: rdata_nxt = {29'h0, mode_r};
      `SCC_OFS_PWM_SCALE: rdata_nxt = {24'h0, pwm_amplitude};
      `SCC_OFS_STATUS: rdata_nxt = {{(32-`SCC_ST_W){1'b0}}, status_r};
      `SCC_OFS_MASK: rdata_nxt = {{(32-`SCC_ST_W){1'b0}}, mask_r};
      `SCC_OFS_HIGH_VEL: rdata_nxt = {9'h0, high_vel_r};
      `SCC_OFS_STATE: rdata_nxt = {28'h0, fullstep_mode, step_loss, above_high_r,
        commutation_active};
      default: rdata_nxt = 32'h0;
    endcase
  end

  // Pin synchroniser, stage two and three must agree
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sync_r <= 3'h0;
      pin_level_r <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], commutation_enable_input};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_level_r <= pin_sync_r[2];
    end
  end

  // Enable decision, combinational from this cycle's velocity
  always @*
  begin
    vel_mag = mag(actual_velocity);
    above_high_nxt = (high_vel_r != 23'h0) && above(vel_mag, high_vel_r);
    if (mode_r[`SCC_MODE_STEPDIR])
      cmt_nxt = pin_level_r;
    else if (min_vel_r == `SCC_MINV_RESET)
      cmt_nxt = 1'b0;
    else
      cmt_nxt = (min_vel_r >= `SCC_MINV_FLOOR)
        && above(vel_mag, min_vel_scaled(min_vel_r));
    // Commutating outside step/direction mode counts as exceeding the high threshold
    above_high_nxt = above_high_nxt || (cmt_nxt && !mode_r[`SCC_MODE_STEPDIR]);
    in_fullstep = above_high_r && mode_r[`SCC_MODE_HS_FULLSTEP];
  end

  assign crossing = above_high_nxt != above_high_r;
  // Crossing cycle masked too, so a hit cannot slip in before the timer starts
  assign stall_mask = supp || crossing;

  scc_ontime #(
    .ONT_W(10),
    .SLT_W(8)
  ) u_ontime (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(commutation_active || in_fullstep),
    .pwm_on(pwm_on),
    .ont_limit(ctrl_r[`SCC_ONT_HI:`SCC_ONT_LO]),
    .slt_limit(ctrl_r[`SCC_SLT_HI:`SCC_SLT_LO]),
    .cmt_limit_hit_r(cmt_hit),
    .step_loss_r(loss_hit)
  );

  scc_suppress u_supp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .crossing(crossing),
    .elec_period(elec_period),
    .suppress_r(supp)
  );

  always @*
  begin
    status_nxt = status_r;
    if (wr_en && avs_address == `SCC_OFS_STATUS)
      status_nxt = status_r & ~avs_writedata[`SCC_ST_W-1:0];
    // Set after clear so a same-cycle event is kept
    if (cmt_nxt && !cmt_prev_r)
      status_nxt[`SCC_ST_CMT_ON] = 1'b1;
    if (!cmt_nxt && cmt_prev_r)
      status_nxt[`SCC_ST_CMT_OFF] = 1'b1;
    if (loss_hit && !stall_mask)
      status_nxt[`SCC_ST_STEP_LOSS] = 1'b1;
    if (crossing)
      status_nxt[`SCC_ST_HIGH_CROSS] = 1'b1;
  end

  // Status and interrupt
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_r <= {`SCC_ST_W{1'b0}};
      irq <= 1'b0;
      cmt_prev_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
      cmt_prev_r <= cmt_nxt;
    end
  end

  // Drive outputs, all registered
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      above_high_r <= 1'b0;
      commutation_active <= 1'b0;
      actual_position <= {POS_W{1'b0}};
      position_load <= 1'b0;
      min_step_velocity <= 23'h0;
      cmt_on_time_limit <= 1'b0;
      step_loss <= 1'b0;
      stall_suppress <= 1'b0;
      adaptive_scaling_off <= 1'b0;
      voltage_pwm_off <= 1'b0;
      chopper_switch <= 1'b0;
      fullstep_mode <= 1'b0;
    end
    else
    begin
      above_high_r <= above_high_nxt;
      commutation_active <= cmt_nxt;
      // Position tracks the sensorless commutation while active
      position_load <= cmt_nxt && commutation_step;
      if (cmt_nxt && commutation_step)
        actual_position <= sensorless_position;
      // Floor for the step rate under load
      min_step_velocity <= cmt_nxt ? min_vel_scaled(min_vel_r) : 23'h0;
      cmt_on_time_limit <= cmt_hit;
      step_loss <= loss_hit && !stall_mask;
      stall_suppress <= stall_mask;
      adaptive_scaling_off <= above_high_nxt;
      voltage_pwm_off <= above_high_nxt;
      chopper_switch <= above_high_nxt && mode_r[`SCC_MODE_HS_CHOPPER];
      fullstep_mode <= above_high_nxt && mode_r[`SCC_MODE_HS_FULLSTEP];
    end
  end
endmodule // scc_top

// *** tb/scc_checker.sv ***
/*
  Port assertions for scc_top: bus handshake, gating outputs,
  position source, on-time and stall masking.
  Assumes a bind onto every scc_top instance.
*/
`timescale 1ns/100ps
module scc_checker #(
  parameter POS_W = 32
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Bus handshake
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Drive outputs and the pwm_on input
  input wire commutation_active,
  input wire [POS_W-1:0] actual_position,
  input wire position_load,
  input wire [22:0] min_step_velocity,
  input wire pwm_on,
  input wire cmt_on_time_limit,
  input wire step_loss,
  input wire stall_suppress,
  input wire adaptive_scaling_off,
  input wire voltage_pwm_off
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_min_zero: assert property (!commutation_active [*2] |-> min_step_velocity == 23'h0)
    else $error("minimum step velocity while idle");
  a_min_low_bits: assert property (min_step_velocity[7:0] == 8'h0)
    else $error("low velocity bits used");
  a_pos_source: assert property ($changed(actual_position) |->
    commutation_active || $past(commutation_active))
    else $error("position moved while idle");
  a_high_pair: assert property (adaptive_scaling_off == voltage_pwm_off)
    else $error("high actions split");
  a_ontime_clear: assert property (!pwm_on [*3] |-> !cmt_on_time_limit)
    else $error("on-time limit without on phase");
  a_stall_masked: assert property (stall_suppress [*3] |-> !step_loss)
    else $error("step loss while suppressed");
  cover property (commutation_active);
  cover property (position_load);
  cover property (cmt_on_time_limit);
  cover property (step_loss);
endmodule // scc_checker

bind scc_top scc_checker #(.POS_W(POS_W)) chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .commutation_active(commutation_active), .actual_position(actual_position),
  .position_load(position_load), .min_step_velocity(min_step_velocity), .pwm_on(pwm_on),
  .cmt_on_time_limit(cmt_on_time_limit), .step_loss(step_loss),
  .stall_suppress(stall_suppress), .adaptive_scaling_off(adaptive_scaling_off),
  .voltage_pwm_off(voltage_pwm_off));

// *** tb/scc_motor_model.sv ***
/*
  Motor and bridge model: chopper on phases on request, period pulses,
  commutation steps with a running position.
  Assumes the block's clock and reset.
*/
`timescale 1ns/100ps
module scc_motor_model (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Bench control
  input wire run,
  // To the block
  output logic pwm_on,
  output logic elec_period,
  output logic commutation_step,
  output logic [7:0] pwm_amplitude,
  output logic [31:0] sensorless_position
);
  logic [3:0] ph_r;
  initial pwm_on = 1'b0;
  // Full drive, so the scaler sits at its top
  assign pwm_amplitude = 8'hff;
  always @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      ph_r <= 4'h0;
      elec_period <= 1'b0;
      commutation_step <= 1'b0;
      sensorless_position <= 32'h0;
    end
    else
    begin
      ph_r <= ph_r + 4'h1;
      elec_period <= (ph_r == 4'hf);
      commutation_step <= run && (ph_r[2:0] == 3'h7);
      // New position rides with its step pulse
      if (run && (ph_r[2:0] == 3'h7))
        sensorless_position <= sensorless_position + 32'h1;
    end
  task automatic on_pulse(input int n);
    pwm_on <= 1'b1;
    repeat (n) @(posedge sys_clk);
    pwm_on <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // scc_motor_model

// *** tb/testbench.sv ***
/*
  Bench for scc_top: Avalon tasks, velocity gating, mode, position,
  on-time and interrupt tests.
  Assumes the motor model on the far side.
*/
`timescale 1ns/100ps
module testbench;
  logic sys_clk, reset_n, rd_en, wr_en, en_in, run, act, pld, lim, sl, sup;
  logic wt, irq, aso, vpo, pon, ep, step, lim_seen, sl_seen, pld_seen, chs, fsm;
  logic [3:0] adr;
  logic [31:0] wd, rdd, vel, spos, apos, v, p;
  logic [7:0] amp;
  logic [22:0] msv;
  int fails, cmp_count, cyc;
  scc_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(rdd),
    .avs_waitrequest(wt), .irq(irq), .actual_velocity(vel), .sensorless_position(spos),
    .commutation_step(step), .commutation_enable_input(en_in), .pwm_on(pon),
    .elec_period(ep), .pwm_amplitude(amp), .commutation_active(act),
    .actual_position(apos), .position_load(pld), .min_step_velocity(msv),
    .cmt_on_time_limit(lim), .step_loss(sl), .stall_suppress(sup),
    .adaptive_scaling_off(aso), .voltage_pwm_off(vpo), .chopper_switch(chs),
    .fullstep_mode(fsm));
  scc_motor_model mdl_u (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
    .pwm_on(pon), .elec_period(ep), .commutation_step(step), .pwm_amplitude(amp),
    .sensorless_position(spos));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (lim)
      lim_seen <= 1'b1;
    if (sl)
      sl_seen <= 1'b1;
    if (pld)
      pld_seen <= 1'b1;
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    wd <= d;
    wr_en <= 1'b1;
    do @(posedge sys_clk); while (wt !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    adr <= a;
    rd_en <= 1'b1;
    do @(posedge sys_clk); while (wt !== 1'b0);
    rd_en <= 1'b0;
    chk(n, e, rdd);
  endtask
  task automatic setv(input logic [31:0] x);
    @(posedge sys_clk);
    vel <= x;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pulse(input int n);
    lim_seen <= 1'b0;
    sl_seen <= 1'b0;
    mdl_u.on_pulse(n);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {reset_n, rd_en, wr_en, en_in, run, lim_seen, sl_seen, pld_seen} = 8'h0;
    adr = 4'h0;
    wd = 32'h0;
    vel = 32'h0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rc(4'h0, 32'h0, "min_vel");
    rc(4'h1, 32'h0, "ctrl");
    wr(4'h3, 32'h11);
    rc(4'h3, 32'hff, "pwm_scale");
    rc(4'h8, 32'h0, "unmapped");
    $display("register test done");
    wr(4'h0, 32'h1ff);
    setv(32'd255);
    chb("act_low", 1'b0, act);
    setv(32'd256);
    chb("act_min", 1'b1, act);
    chb("suppress", 1'b1, sup);
    chk("min_step", 32'h100, {9'h0, msv});
    chb("high_acts", 1'b1, aso & vpo);
    setv(-32'sd256);
    chb("act_neg", 1'b1, act);
    run <= 1'b1;
    repeat (100) @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("pos", spos, apos);
    chb("pld_seen", 1'b1, pld_seen);
    chb("suppress_end", 1'b0, sup);
    $display("velocity test done");
    wr(4'h1, 32'h020014);
    wr(4'h4, 32'hf);
    wr(4'h5, 32'h4);
    pulse(15);
    chb("lim_short", 1'b0, lim_seen);
    pulse(25);
    chb("lim_long", 1'b1, lim_seen);
    chb("irq_short", 1'b0, irq);
    pulse(40);
    chb("irq_loss", 1'b1, irq);
    chb("sl_seen", 1'b1, sl_seen);
    wr(4'h5, 32'h0);
    repeat (2) @(posedge sys_clk);
    chb("irq_mask", 1'b0, irq);
    wr(4'h4, 32'h4);
    wr(4'h5, 32'h4);
    repeat (2) @(posedge sys_clk);
    chb("irq_clr", 1'b0, irq);
    wr(4'h1, 32'h14);
    pulse(40);
    chb("irq_off", 1'b0, irq);
    chb("sl_off", 1'b0, sl_seen);
    $display("on-time test done");
    setv(-32'sd255);
    chb("act_neg_low", 1'b0, act);
    p = spos;
    pld_seen <= 1'b0;
    run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    run <= 1'b0;
    chk("pos_hold", p, apos);
    chb("pld_idle", 1'b0, pld_seen);
    wr(4'h0, 32'h0);
    setv(32'h7fffff);
    chb("act_zero", 1'b0, act);
    wr(4'h6, 32'h100);
    wr(4'h2, 32'h6);
    repeat (2) @(posedge sys_clk);
    chb("fullstep", 1'b1, fsm);
    chb("chopper", 1'b1, chs);
    rc(4'h2, 32'h6, "mode");
    rc(4'h7, 32'ha, "state");
    pulse(25);
    chb("lim_fullstep", 1'b1, lim_seen);
    $display("fullstep test done");
    wr(4'h2, 32'h1);
    en_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chb("act_pin", 1'b1, act);
    en_in <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chb("act_pin_off", 1'b0, act);
    $display("step/dir test done");
    end_of_test();
  end
endmodule // testbench
